// ==== capture_pkg.sv ====
package capture_pkg;

    // companion timer width and instruction clock ratio
    localparam int unsigned TIMER_W = 16;
    localparam int unsigned CLK_SYS_HZ = 40_000_000;
    localparam int unsigned INSTR_HZ = CLK_SYS_HZ / 4;
    localparam int unsigned INSTR_DIV = CLK_SYS_HZ / INSTR_HZ;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

    // register byte offsets
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_TIMER_CTRL = 5'h04;
    localparam logic [4:0] OFS_PIN_CTRL = 5'h08;
    localparam logic [4:0] OFS_TIMER = 5'h0c;
    localparam logic [4:0] OFS_CAPTURE = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_MASK = 5'h18;

    // capture_mode_select codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [1:0] MODE_CAP_GROUP = 2'h1;

    // event selector, low two bits of a capture mode
    localparam logic [1:0] SEL_FALL = 2'h0;
    localparam logic [1:0] SEL_RISE = 2'h1;
    localparam logic [1:0] SEL_RISE4 = 2'h2;
    localparam logic [1:0] SEL_RISE16 = 2'h3;

    // values after reset
    localparam logic [3:0] MODE_RST = MODE_OFF;
    localparam logic PIN_DIR_RST = 1'b1;
    localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [3:0] PRESCALE_RST = 4'h0;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avs_req_t;

endpackage : capture_pkg

// ==== signal_sync.sv ====
`timescale 1ns/10ps
module signal_sync
    import capture_pkg::*;
#(
    parameter int unsigned WIDTH = 2
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // the first stage feeds only the second one
    always_comb
    begin
        d.meta = async_in;
        d.stable = q.meta;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign sync_out = q.stable;

endmodule : signal_sync

// ==== edge_prescaler.sv ====
`timescale 1ns/10ps
module edge_prescaler
    import capture_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic pin_in,
    input wire logic enable_in,
    input wire logic [1:0] sel_in,
    output logic event_out
);

    typedef struct packed {
        logic prev;
        logic [3:0] cnt;
        logic hit;
    } edge_state_t;

    edge_state_t q;
    edge_state_t d;
    logic rise;
    logic fall;

    // edges are judged on instruction clock ticks only
    assign rise = pin_in & ~q.prev;
    assign fall = ~pin_in & q.prev;

    // the counter is shared by both prescaled modes, so a switch between them keeps it
    always_comb
    begin
        d = q;
        d.hit = 1'b0;
        if (tick_in)
            d.prev = pin_in;
        if (!enable_in)
            d.cnt = PRESCALE_RST;
        else if (tick_in)
        begin
            unique case (sel_in)
                SEL_FALL: d.hit = fall;
                SEL_RISE: d.hit = rise;
                SEL_RISE4:
                begin
                    d.cnt = q.cnt + 4'h1;
                    if (!rise)
                        d.cnt = q.cnt;
                    d.hit = rise && (q.cnt[1:0] == 2'h3);
                end
                SEL_RISE16:
                begin
                    d.cnt = q.cnt + 4'h1;
                    if (!rise)
                        d.cnt = q.cnt;
                    d.hit = rise && (q.cnt == 4'hf);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign event_out = q.hit;

    chk_off_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !enable_in |=> (q.cnt == 4'h0) && !event_out)
        else $error("prescaler not cleared while off");
    chk_fall_event: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (enable_in && tick_in && sel_in == SEL_FALL && fall) |=> event_out)
        else $error("falling edge did not raise an event");
    chk_sixteenth_rise: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (enable_in && tick_in && sel_in == SEL_RISE16 && rise) |=> event_out == $past(q.cnt == 4'hf))
        else $error("sixteenth rising edge miscounted");
    cov_sixteenth: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        event_out && $past(sel_in) == SEL_RISE16);

endmodule : edge_prescaler

// ==== input_capture_unit.sv ====
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module input_capture_unit
    import capture_pkg::*;
#(
    parameter int unsigned CAPTURE_W = TIMER_W
)
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire avs_req_t avs_req_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic capture_pin_in,
    output logic capture_pin_out,
    output logic capture_pin_oe_out,
    input wire logic timer_ext_clk_in,
    input wire logic sleep_in,
    output logic irq_out
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [3:0] mode;
        logic tmr_on;
        logic tmr_ext;
        logic pin_dir;
        logic pin_latch;
        logic [CAPTURE_W-1:0] timer;
        logic [CAPTURE_W-1:0] cap;
        logic flag;
        logic mask;
        logic [1:0] div;
        logic ext_prev;
    } unit_state_t;

    localparam unit_state_t STATE_RST = '{
        ack: 1'b0,
        rdata: RDATA_RST,
        mode: MODE_RST,
        tmr_on: 1'b0,
        tmr_ext: 1'b0,
        pin_dir: PIN_DIR_RST,
        pin_latch: 1'b0,
        timer: TIMER_RST,
        cap: TIMER_RST,
        flag: 1'b0,
        mask: 1'b0,
        div: 2'h0,
        ext_prev: 1'b0
    };

    logic [1:0] rst_pipe_q;
    logic rst_n;
    unit_state_t q;
    unit_state_t d;
    logic [1:0] pins_sync;
    logic pin_sync;
    logic ext_sync;
    logic instr_tick;
    logic capture_on;
    logic cap_event;
    logic timer_step;
    logic req_any;
    logic wr_acc;
    logic rd_first;
    logic rd_clr;
    logic [4:0] word_addr;
    logic [31:0] rd_mux;

    // reset asserts at once and is released two clock edges later
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rst_pipe_q <= 2'h0;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end

    assign rst_n = rst_pipe_q[1];

    // the pin input is sampled whatever the direction bit says
    signal_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .async_in({timer_ext_clk_in, capture_pin_in}),
        .sync_out(pins_sync)
    );

    assign pin_sync = pins_sync[0];
    assign ext_sync = pins_sync[1];

    // instruction clock tick, a quarter of the system clock
    assign instr_tick = (q.div == INSTR_DIV_LAST);
    assign capture_on = (q.mode[3:2] == MODE_CAP_GROUP);

    // edge detector and event prescaler, same logic for every instance
    edge_prescaler u_edge (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .tick_in(instr_tick),
        .pin_in(pin_sync),
        .enable_in(capture_on),
        .sel_in(q.mode[1:0]),
        .event_out(cap_event)
    );

    // timer advances on instruction ticks, frozen in sleep, or on external clock rises
    assign timer_step = q.tmr_on && (q.tmr_ext ? (ext_sync && !q.ext_prev)
                                               : (instr_tick && !sleep_in));

    // bus strobes: one wait cycle, then the access is accepted
    assign req_any = avs_req_in.read || avs_req_in.write;
    assign wr_acc = avs_req_in.write && q.ack;
    assign rd_first = avs_req_in.read && !q.ack;
    assign word_addr = {avs_req_in.address[4:2], 2'h0};
    // status cleared when its value is latched, so a later event is never hidden
    assign rd_clr = rd_first && (word_addr == OFS_STATUS);

    // read multiplexer, unmapped words read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (word_addr)
            OFS_CONTROL: rd_mux[3:0] = q.mode;
            OFS_TIMER_CTRL: rd_mux[1:0] = {q.tmr_ext, q.tmr_on};
            OFS_PIN_CTRL: rd_mux[1:0] = {q.pin_latch, q.pin_dir};
            OFS_TIMER: rd_mux[CAPTURE_W-1:0] = q.timer;
            OFS_CAPTURE: rd_mux[CAPTURE_W-1:0] = q.cap;
            OFS_STATUS: rd_mux[0] = q.flag;
            OFS_MASK: rd_mux[0] = q.mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // next-state logic for the whole unit
    always_comb
    begin
        d = q;
        d.div = q.div + 2'h1;
        d.ext_prev = ext_sync;
        d.ack = req_any && !q.ack;
        if (req_any && !q.ack)
            d.rdata = rd_mux;
        if (timer_step)
            d.timer = q.timer + 16'h0001;
        if (wr_acc)
        begin
            unique case (word_addr)
                OFS_CONTROL:
                    if (avs_req_in.byteenable[0])
                        d.mode = avs_req_in.writedata[3:0];
                OFS_TIMER_CTRL:
                    if (avs_req_in.byteenable[0])
                    begin
                        d.tmr_on = avs_req_in.writedata[0];
                        d.tmr_ext = avs_req_in.writedata[1];
                    end
                OFS_PIN_CTRL:
                    if (avs_req_in.byteenable[0])
                    begin
                        d.pin_dir = avs_req_in.writedata[0];
                        d.pin_latch = avs_req_in.writedata[1];
                    end
                OFS_TIMER:
                begin
                    if (avs_req_in.byteenable[0])
                        d.timer[7:0] = avs_req_in.writedata[7:0];
                    if (avs_req_in.byteenable[1])
                        d.timer[15:8] = avs_req_in.writedata[15:8];
                end
                OFS_CAPTURE:
                begin
                    if (avs_req_in.byteenable[0])
                        d.cap[7:0] = avs_req_in.writedata[7:0];
                    if (avs_req_in.byteenable[1])
                        d.cap[15:8] = avs_req_in.writedata[15:8];
                end
                OFS_MASK:
                    if (avs_req_in.byteenable[0])
                        d.mask = avs_req_in.writedata[0];
                default:
                    d.mode = q.mode; // status and unmapped words ignore writes
            endcase
        end
        // a capture beats a software write of the same register; no overrun guard
        if (cap_event)
            d.cap = q.timer;
        // a new capture wins over the read clear in the same cycle
        d.flag = (q.flag && !rd_clr) || cap_event;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            q <= STATE_RST;
        else
            q <= d;
    end

    // outputs
    assign avs_readdata_out = q.rdata;
    assign avs_waitrequest_out = req_any && !q.ack;
    assign capture_pin_out = q.pin_latch;
    assign capture_pin_oe_out = !q.pin_dir; // pin drives while direction bit is 0
    assign irq_out = q.flag && q.mask;

    chk_cap_takes_timer: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        cap_event |=> q.cap == $past(q.timer))
        else $error("capture did not store the timer count");
    chk_flag_with_load: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        cap_event |=> q.flag && (q.cap == $past(q.timer)))
        else $error("flag not set with the capture load");
    chk_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (q.flag && !rd_clr) |=> q.flag)
        else $error("capture flag dropped without a status read");
    chk_read_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (rd_clr && !cap_event) |=> !q.flag)
        else $error("status read did not clear the flag");
    chk_overwrite_value: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (q.flag && cap_event) |=> q.cap == $past(q.timer) && q.flag)
        else $error("unread capture was not overwritten");
    chk_sleep_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (sleep_in && !q.tmr_ext && !wr_acc) |=> q.timer == $past(q.timer))
        else $error("timer advanced in sleep on instruction clock");
    chk_tick_period: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        instr_tick |=> !instr_tick [*3] ##1 instr_tick)
        else $error("instruction tick period is not four cycles");
    chk_bus_one_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (req_any && !q.ack) |=> !avs_waitrequest_out)
        else $error("bus access waited more than one cycle");
    chk_irq_masked: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        !q.mask |-> !irq_out)
        else $error("interrupt raised while masked");

    // register side: each write is judged against the request that carried it,
    // timer and capture paths against their own enables

    // a control write lands on the next edge
    chk_mode_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (wr_acc && word_addr == OFS_CONTROL && avs_req_in.byteenable[0])
            |=> q.mode == $past(avs_req_in.writedata[3:0]))
        else $error("control write did not set the capture mode");

    // a full timer write beats the increment of the same cycle
    chk_timer_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (wr_acc && word_addr == OFS_TIMER && avs_req_in.byteenable[1:0] == 2'h3)
            |=> q.timer == $past(avs_req_in.writedata[15:0]))
        else $error("timer write was lost");

    // lane 0 alone still writes the low byte
    chk_timer_low_lane: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (wr_acc && word_addr == OFS_TIMER && avs_req_in.byteenable[1:0] == 2'h1)
            |=> q.timer[7:0] == $past(avs_req_in.writedata[7:0]))
        else $error("timer low byte lane not written");

    // a stopped timer keeps its count
    chk_timer_off_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (!q.tmr_on && !wr_acc) |=> q.timer == $past(q.timer))
        else $error("stopped timer changed");

    // on the instruction clock the timer steps once per tick while awake
    chk_timer_int_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (q.tmr_on && !q.tmr_ext && instr_tick && !sleep_in && !wr_acc)
            |=> q.timer == $past(q.timer) + 16'h0001)
        else $error("timer missed an instruction tick");

    // the external clock keeps the timer counting, sleep or not
    chk_timer_ext_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (q.tmr_on && q.tmr_ext && ext_sync && !q.ext_prev && !wr_acc)
            |=> q.timer == $past(q.timer) + 16'h0001)
        else $error("timer missed an external clock edge");

    // no event leaves the prescaler while capture is off
    chk_off_no_event: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        !capture_on |=> !cap_event)
        else $error("event raised outside capture mode");

    // the flag rises only through a capture
    chk_flag_needs_event: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (!q.flag && !cap_event) |=> !q.flag)
        else $error("flag set without a capture");

    // the stored value changes only by a capture or a write
    chk_cap_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (!cap_event && !wr_acc) |=> q.cap == $past(q.cap))
        else $error("capture value changed without cause");

    // the status read returns the flag as it stood before the clear
    chk_status_data: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        rd_clr |=> avs_readdata_out == {31'h0000_0000, $past(q.flag)})
        else $error("status read returned a wrong flag");

    // a synchronised rise is caught within one tick period
    chk_rise_latency: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (capture_on && q.mode[1:0] == SEL_RISE && $rose(pin_sync)) |-> ##[1:4] cap_event)
        else $error("rising edge not captured in time");

    // a synchronised fall is caught within one tick period
    chk_fall_latency: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (capture_on && q.mode[1:0] == SEL_FALL && $fell(pin_sync)) |-> ##[1:4] cap_event)
        else $error("falling edge not captured in time");

    // one accept per request, so no write lands twice
    chk_ack_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        q.ack |=> !q.ack)
        else $error("bus accept lasted more than one cycle");

    // a mask write lands on the next edge
    chk_mask_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (wr_acc && word_addr == OFS_MASK && avs_req_in.byteenable[0])
            |=> q.mask == $past(avs_req_in.writedata[0]))
        else $error("mask write was lost");

    // direction and latch reach the pin outputs on the next edge
    chk_pin_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (wr_acc && word_addr == OFS_PIN_CTRL && avs_req_in.byteenable[0])
            |=> capture_pin_oe_out == !$past(avs_req_in.writedata[0])
                && capture_pin_out == $past(avs_req_in.writedata[1]))
        else $error("pin control write did not reach the pin");

    cov_capture: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        cap_event ##1 irq_out);
    cov_overwrite: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        q.flag && cap_event);
    cov_output_pin_capture: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        capture_pin_oe_out && cap_event);
    cov_status_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        rd_clr && q.flag);

endmodule : input_capture_unit

// ==== capture_event_source.sv ====
`timescale 1ns/10ps
// far-side signal source on the capture pin; it yields while the unit drives the pin
module capture_event_source
#(
    parameter int unsigned HOLD = 12
)
(
    input wire logic clk_sys_in,
    input wire logic drive_in,
    input wire logic oe_in,
    output logic level_out
);
    logic src_q = 1'b0;

    // resolved wire: the unit's own driver wins, and its level is still what the capture logic sees
    assign level_out = oe_in ? drive_in : src_q;

    // each level is held well past one instruction tick period, otherwise the edge could be missed
    task automatic pulses(input int n);
        repeat (n)
        begin
            src_q <= 1'b1;
            repeat (HOLD) @(posedge clk_sys_in);
            src_q <= 1'b0;
            repeat (HOLD) @(posedge clk_sys_in);
        end
    endtask : pulses
endmodule : capture_event_source

// ==== tb_input_capture_unit.sv ====
`timescale 1ns/10ps
`define check(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_input_capture_unit;
    import capture_pkg::*;

    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    avs_req_t req = '0;
    logic [31:0] rdata;
    logic wait_rq;
    logic pin_level;
    logic pin_drv;
    logic pin_oe;
    logic ext_clk = 1'b0;
    logic sleep = 1'b0;
    logic irq;
    logic [31:0] rd;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;

    // system clock, 25 ns period
    always #12.5 clk_sys_in = ~clk_sys_in;

    input_capture_unit #(.CAPTURE_W(TIMER_W)) DUT (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .avs_req_in(req),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_rq),
        .capture_pin_in(pin_level),
        .capture_pin_out(pin_drv),
        .capture_pin_oe_out(pin_oe),
        .timer_ext_clk_in(ext_clk),
        .sleep_in(sleep),
        .irq_out(irq)
    );

    capture_event_source src (
        .clk_sys_in(clk_sys_in),
        .drive_in(pin_drv),
        .oe_in(pin_oe),
        .level_out(pin_level)
    );

    task automatic close_out;
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // a hung handshake ends here instead of running forever
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : idle

    // one avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be);
        req <= '{read: !wr, write: wr, address: a, writedata: wd, byteenable: be};
        do @(posedge clk_sys_in); while (wait_rq !== 1'b0);
        rd = rdata;
        req <= '0;
        @(posedge clk_sys_in);
    endtask : bus

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd, 4'hf);
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        `check(nm, exp, rd)
    endtask : rd_chk

    // drop any flag left by earlier traffic or a mode change
    task automatic clear_flag;
        bus(1'b0, OFS_STATUS, 32'h0000_0000, 4'hf);
    endtask : clear_flag

    task automatic t_reset;
        rd_chk(OFS_CONTROL, 32'h0000_0000, "control after reset");
        rd_chk(OFS_PIN_CTRL, 32'h0000_0001, "pin ctrl after reset");
        rd_chk(OFS_STATUS, 32'h0000_0000, "status after reset");
        rd_chk(5'h1c, 32'h0000_0000, "unmapped read");
        `check("pin enable after reset", 1'b0, pin_oe)
        `check("irq after reset", 1'b0, irq)
    endtask : t_reset

    // single byte lanes and an unaligned address reach the right register bits
    task automatic t_byte_lanes;
        wr_reg(OFS_TIMER, 32'h0000_1234);
        bus(1'b1, OFS_TIMER, 32'h0000_abcd, 4'h1);
        rd_chk(OFS_TIMER, 32'h0000_12cd, "timer low lane");
        bus(1'b1, OFS_TIMER, 32'h0000_ef00, 4'h2);
        rd_chk(OFS_TIMER, 32'h0000_efcd, "timer high lane");
        bus(1'b1, OFS_MASK, 32'h0000_0001, 4'h0);
        rd_chk(OFS_MASK, 32'h0000_0000, "mask with no lane");
        rd_chk(5'h0b, 32'h0000_0001, "unaligned pin ctrl");
    endtask : t_byte_lanes

    // every event type, with the timer stopped so the captured count is known
    task automatic t_modes;
        logic [3:0] md [4];
        int cnt [4];
        logic [15:0] val;
        md = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
        cnt = '{1, 1, 4, 16};
        wr_reg(OFS_TIMER_CTRL, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            val = 16'h3c5a + 16'(i) * 16'h1111;
            wr_reg(OFS_TIMER, {16'h0000, val});
            wr_reg(OFS_CONTROL, 32'h0000_0000);
            wr_reg(OFS_CONTROL, {28'h000_0000, md[i]});
            clear_flag();
            src.pulses(cnt[i] - 1);
            idle(12);
            rd_chk(OFS_STATUS, 32'h0000_0000, "flag before last edge");
            src.pulses(1);
            idle(12);
            rd_chk(OFS_CAPTURE, {16'h0000, val}, "captured count");
            rd_chk(OFS_STATUS, 32'h0000_0001, "flag after capture");
        end
    endtask : t_modes

    task automatic t_overwrite_irq;
        wr_reg(OFS_CONTROL, {28'h000_0000, MODE_CAP_RISE});
        clear_flag();
        wr_reg(OFS_TIMER, 32'h0000_5a5a);
        src.pulses(1);
        idle(12);
        wr_reg(OFS_TIMER, 32'h0000_6b6b);
        src.pulses(1);
        idle(40);
        rd_chk(OFS_CAPTURE, 32'h0000_6b6b, "overwritten capture");
        `check("irq masked", 1'b0, irq)
        wr_reg(OFS_MASK, 32'h0000_0001);
        `check("irq unmasked", 1'b1, irq)
        rd_chk(OFS_STATUS, 32'h0000_0001, "sticky flag");
        `check("irq after clear", 1'b0, irq)
        rd_chk(OFS_STATUS, 32'h0000_0000, "flag cleared");
        wr_reg(OFS_MASK, 32'h0000_0000);
    endtask : t_overwrite_irq

    // leaving capture mode must restart the every-4th count
    task automatic t_prescale_clear;
        wr_reg(OFS_CONTROL, {28'h000_0000, MODE_CAP_RISE4});
        clear_flag();
        src.pulses(2);
        wr_reg(OFS_CONTROL, 32'h0000_0000);
        wr_reg(OFS_CONTROL, {28'h000_0000, MODE_CAP_RISE4});
        clear_flag();
        src.pulses(3);
        idle(12);
        rd_chk(OFS_STATUS, 32'h0000_0000, "prescaler restarted");
        src.pulses(1);
        idle(12);
        rd_chk(OFS_STATUS, 32'h0000_0001, "fourth edge after restart");
    endtask : t_prescale_clear

    // with the pin driven out, a port latch write still makes a capture
    task automatic t_port_drive;
        wr_reg(OFS_CONTROL, {28'h000_0000, MODE_CAP_RISE});
        wr_reg(OFS_PIN_CTRL, 32'h0000_0000);
        idle(12);
        clear_flag();
        `check("pin enable", 1'b1, pin_oe)
        wr_reg(OFS_PIN_CTRL, 32'h0000_0002);
        idle(12);
        `check("pin latch", 1'b1, pin_drv)
        rd_chk(OFS_STATUS, 32'h0000_0001, "capture from port write");
        wr_reg(OFS_PIN_CTRL, 32'h0000_0001);
    endtask : t_port_drive

    task automatic t_sleep;
        sleep <= 1'b1;
        wr_reg(OFS_TIMER_CTRL, 32'h0000_0001);
        wr_reg(OFS_TIMER, 32'h0000_0000);
        idle(40);
        rd_chk(OFS_TIMER, 32'h0000_0000, "timer held in sleep");
        sleep <= 1'b0;
        idle(40);
        bus(1'b0, OFS_TIMER, 32'h0000_0000, 4'hf);
        `check("timer resumes after sleep", 1'b1, rd[15:0] > 16'h0008)
        sleep <= 1'b1;
        wr_reg(OFS_TIMER_CTRL, 32'h0000_0003);
        wr_reg(OFS_TIMER, 32'h0000_0000);
        clear_flag();
        repeat (5)
        begin
            ext_clk <= 1'b1;
            idle(4);
            ext_clk <= 1'b0;
            idle(4);
        end
        idle(8);
        src.pulses(1);
        idle(12);
        rd_chk(OFS_CAPTURE, 32'h0000_0005, "capture in sleep");
        rd_chk(OFS_STATUS, 32'h0000_0001, "flag in sleep");
        sleep <= 1'b0;
    endtask : t_sleep

    initial
    begin
        idle(3);
        arst_n_in <= 1'b1;
        idle(4);
        t_reset();
        t_byte_lanes();
        t_modes();
        t_overwrite_irq();
        t_prescale_clear();
        t_port_drive();
        t_sleep();
        close_out();
    end
endmodule : tb_input_capture_unit
